// ---- rtl/ars_consts.vh ----
// timing, encodings and field constants for the alarm relay supervisor
`ifndef ARS_CONSTS_VH
`define ARS_CONSTS_VH

`define ARS_CLK_HZ          250000000
`define ARS_RESET_HOLD_MS   3000
`define ARS_RESET_HOLD_CYC  ((`ARS_CLK_HZ / 1000) * `ARS_RESET_HOLD_MS)
`define ARS_SELFTEST_CYC    250000
`define ARS_LEVEL_MIN       3'h1
`define ARS_LEVEL_MAX       3'h5
`define ARS_LOSS_CODE_W     4
`define ARS_EVT_W           8
`define ARS_EVT_READY_LOST  4'h1
`define ARS_EVT_MAIN        4'h2
`define ARS_EVT_PRE         4'h3
`define ARS_EVT_OVSPD       4'h4
`define ARS_EVT_CLEARED     4'h5
`define ARS_EVT_OFFSET      4'h6
`define ARS_ERR_COMM        4'h1
`define ARS_ERR_SENSOR      4'h2
`define ARS_ERR_OTHER       4'h3

`endif

// ---- rtl/ars_hold_timer.v ----
// counts a level continuously high; restarts on any drop
`timescale 1ns/100ps
module ars_hold_timer
#(
    parameter W     = 30,
    parameter LIMIT = 750000000
)
(
    // clock and reset
    input  wire         clk_in,
    input  wire         rst_in,
    // level and result
    input  wire         level_in,
    output reg          done_out
);
    localparam [W-1:0] LIM = LIMIT - 1;
    reg [W-1:0] cnt_r;

    always @(posedge clk_in)
    begin
        if (rst_in || !level_in)
        begin
            cnt_r    <= {W{1'b0}};
            done_out <= 1'b0;
        end
        else if (cnt_r != LIM)
        begin
            cnt_r    <= cnt_r + {{(W-1){1'b0}}, 1'b1};
            done_out <= 1'b0;
        end
        else
        begin
            done_out <= 1'b1;
        end
    end
endmodule

// ---- rtl/ars_sync2.v ----
// two flip-flop synchroniser for a bundle of pin levels
`timescale 1ns/100ps
module ars_sync2
#(
    parameter W = 1
)
(
    // clock and reset
    input  wire         clk_in,
    input  wire         rst_in,
    // levels
    input  wire [W-1:0] d_in,
    output reg  [W-1:0] q_out
);
    reg [W-1:0] meta_r;

    always @(posedge clk_in)
    begin
        if (rst_in)
        begin
            meta_r <= {W{1'b0}};
            q_out  <= {W{1'b0}};
        end
        else
        begin
            meta_r <= d_in;
            q_out  <= meta_r;
        end
    end
endmodule

// ---- rtl/ars_supervisor.v ----
// alarm, readiness and relay supervision of the condition evaluator
`timescale 1ns/100ps
`include "ars_consts.vh"
module ars_supervisor
#(
    parameter DW           = 12,
    parameter SW           = 16,
    parameter PW           = 16,
    parameter HOLD_CYC     = `ARS_RESET_HOLD_CYC,
    parameter SELFTEST_CYC = `ARS_SELFTEST_CYC,
    parameter QUAL_CYC     = 1000,
    parameter PRE_DIV      = 250000,
    parameter LVL_BASE     = 12'h200,
    parameter LVL_STEP     = 12'h080
)
(
    // clock and reset
    input  wire                 clk_in,
    input  wire                 rst_in,
    // pins: reset button, communication fault, sensor present, supply ok
    input  wire                 reset_button_in,
    input  wire                 comm_error_in,
    input  wire                 sensor_ok_in,
    input  wire                 supply_ok_in,
    // measurements from acquisition, one sample strobe
    input  wire                 sample_in,
    input  wire [DW-1:0]        thermo_a_in,
    input  wire [DW-1:0]        thermo_b_in,
    input  wire [DW-1:0]        rise_in,
    input  wire [SW-1:0]        speed_rpm_in,
    input  wire                 encoder_zero_in,
    input  wire                 shaft_forward_in,
    input  wire                 shaft_step_in,
    // configuration
    input  wire [2:0]           sens_level_in,
    input  wire [DW-1:0]        pre_level_in,
    input  wire [DW-1:0]        rise_limit_in,
    input  wire [SW-1:0]        min_speed_in,
    input  wire [SW-1:0]        overspeed_rpm_in,
    input  wire [15:0]          pre_holdoff_in,
    input  wire                 r1_pre_en_in,
    input  wire                 r1_ovs_en_in,
    input  wire                 r2_main_en_in,
    input  wire                 r2_pre_en_in,
    input  wire                 r2_ovs_en_in,
    // calibration menu
    input  wire                 cal_start_in,
    input  wire                 cal_exit_in,
    // remote command (never clears alarms)
    input  wire                 remote_clear_in,
    // relays and indicators
    output reg                  ready_led_out,
    output reg                  ready_relay_out,
    output reg                  relay1_out,
    output reg                  relay2_out,
    output reg                  main_alarm_out,
    output reg                  pre_alarm_out,
    output reg                  ovs_alarm_out,
    output reg  [`ARS_LOSS_CODE_W-1:0] err_code_out,
    // calibration result to nonvolatile store
    output reg                  cal_busy_out,
    output reg  [PW-1:0]        nv_offset_out,
    output reg                  nv_write_out,
    // logger stream
    output reg                  log_valid_out,
    output reg  [`ARS_EVT_W-1:0] log_tag_out,
    output reg  [DW-1:0]        log_data_out
);
    wire [3:0] pins_s;
    wire       btn_s    = pins_s[0];
    wire       comm_s   = pins_s[1];
    wire       sensor_s = pins_s[2];
    wire       supply_s = pins_s[3];
    wire       hold_done;

    ars_sync2 #(.W(4)) u_sync (
        .clk_in (clk_in),
        .rst_in (rst_in),
        .d_in   ({supply_ok_in, sensor_ok_in, comm_error_in,
                  reset_button_in}),
        .q_out  (pins_s)
    );

    // short presses restart the count
    ars_hold_timer #(.W(32), .LIMIT(HOLD_CYC)) u_hold (
        .clk_in   (clk_in),
        .rst_in   (rst_in),
        .level_in (btn_s),
        .done_out (hold_done)
    );

    // level 1..5 maps onto rising thresholds; out of range clamps
    function [DW-1:0] level_thresh;
        input [2:0] lvl;
        reg   [2:0] l;
        begin
            l = (lvl < `ARS_LEVEL_MIN) ? `ARS_LEVEL_MIN :
                (lvl > `ARS_LEVEL_MAX) ? `ARS_LEVEL_MAX : lvl;
            level_thresh = LVL_BASE + LVL_STEP * {{(DW-3){1'b0}}, l};
        end
    endfunction

    function [DW-1:0] max2;
        input [DW-1:0] a;
        input [DW-1:0] b;
        begin
            max2 = (a > b) ? a : b;
        end
    endfunction

    // self test period and ready state
    reg [31:0] st_cnt_r;
    reg        comm_lock_r;
    reg        ready_r;
    reg        ready_lost_evt_r;
    always @(posedge clk_in)
    begin
        if (rst_in)
        begin
            st_cnt_r         <= 32'h0;
            comm_lock_r      <= 1'b0;
            ready_r          <= 1'b0;
            ready_lost_evt_r <= 1'b0;
            err_code_out     <= {`ARS_LOSS_CODE_W{1'b0}};
        end
        else
        begin
            ready_lost_evt_r <= 1'b0;
            // only a restart removes a latched communication fault
            if (comm_s)
                comm_lock_r <= 1'b1;
            if (st_cnt_r == SELFTEST_CYC - 1)
            begin
                st_cnt_r <= 32'h0;
                if (comm_s || comm_lock_r || !sensor_s || !supply_s)
                begin
                    ready_r <= 1'b0;
                    if (ready_r)
                        ready_lost_evt_r <= 1'b1;
                    err_code_out <= (comm_s || comm_lock_r) ?
                                    `ARS_ERR_COMM :
                                    (!sensor_s ? `ARS_ERR_SENSOR :
                                     `ARS_ERR_OTHER);
                end
                else
                begin
                    ready_r      <= 1'b1;
                    err_code_out <= {`ARS_LOSS_CODE_W{1'b0}};
                end
            end
            else
                st_cnt_r <= st_cnt_r + 32'h1; // periodic
        end
    end

    // evaluation runs on each sample strobe while a sensor is present
    wire [DW-1:0] peak     = max2(thermo_a_in, thermo_b_in);
    wire          eval_ok  = sample_in && sensor_s;
    wire          main_cnd = peak > level_thresh(sens_level_in)
                             && rise_in > rise_limit_in
                             && speed_rpm_in > min_speed_in;
    wire          pre_cnd  = peak > pre_level_in;
    wire          ovs_cnd  = speed_rpm_in > overspeed_rpm_in;

    reg [31:0] qual_r;
    reg [31:0] pre_div_r;
    reg [15:0] pre_idle_r;
    reg        main_r;
    reg        pre_r;
    reg        ovs_r;
    reg        main_set_evt_r;
    reg        pre_set_evt_r;
    reg        ovs_set_evt_r;
    reg        clr_evt_r;
    always @(posedge clk_in)
    begin
        if (rst_in)
        begin
            qual_r         <= 32'h0;
            pre_div_r      <= 32'h0;
            pre_idle_r     <= 16'h0;
            main_r         <= 1'b0;
            pre_r          <= 1'b0;
            ovs_r          <= 1'b0;
            main_set_evt_r <= 1'b0;
            pre_set_evt_r  <= 1'b0;
            ovs_set_evt_r  <= 1'b0;
            clr_evt_r      <= 1'b0;
        end
        else
        begin
            main_set_evt_r <= 1'b0;
            pre_set_evt_r  <= 1'b0;
            ovs_set_evt_r  <= 1'b0;
            clr_evt_r      <= 1'b0;
            if (eval_ok)
            begin
                if (main_cnd && ready_r)
                begin
                    if (qual_r != QUAL_CYC)
                        qual_r <= qual_r + 32'h1;
                end
                else
                    qual_r <= 32'h0;
            end
            // a set in the same cycle as a clear wins; remote clear blocks the button clear
            if (hold_done && !remote_clear_in)
            begin
                main_r    <= 1'b0;
                ovs_r     <= 1'b0;
                clr_evt_r <= main_r | ovs_r;
            end
            if (eval_ok && ready_r && main_cnd && qual_r == QUAL_CYC)
            begin
                main_r         <= 1'b1;
                main_set_evt_r <= !main_r;
            end
            if (eval_ok && ovs_cnd)
            begin
                ovs_r         <= 1'b1;
                ovs_set_evt_r <= !ovs_r;
            end
            // pre-alarm hold-off counts in coarse ticks
            if (eval_ok && pre_cnd)
            begin
                pre_r         <= 1'b1;
                pre_set_evt_r <= !pre_r;
                pre_idle_r    <= 16'h0;
                pre_div_r     <= 32'h0;
            end
            else if (pre_r)
            begin
                if (pre_div_r == PRE_DIV - 1)
                begin
                    pre_div_r <= 32'h0;
                    if (pre_idle_r >= pre_holdoff_in)
                        pre_r <= 1'b0;
                    else
                        pre_idle_r <= pre_idle_r + 16'h1;
                end
                else
                    pre_div_r <= pre_div_r + 32'h1;
            end
        end
    end

    // encoder offset search: count steps forward to the zero mark
    reg          cal_run_r;
    reg          cal_found_r;
    reg [PW-1:0] cal_cnt_r;
    always @(posedge clk_in)
    begin
        if (rst_in)
        begin
            cal_run_r     <= 1'b0;
            cal_found_r   <= 1'b0;
            cal_cnt_r     <= {PW{1'b0}};
            nv_offset_out <= {PW{1'b0}};
            nv_write_out  <= 1'b0;
            cal_busy_out  <= 1'b0;
        end
        else
        begin
            nv_write_out <= 1'b0;
            if (cal_start_in && !cal_run_r)
            begin
                cal_run_r   <= 1'b1;
                cal_found_r <= 1'b0;
                cal_cnt_r   <= {PW{1'b0}};
            end
            else if (cal_run_r && shaft_step_in && shaft_forward_in)
            begin
                // operator positioned shaft at firing_dead_centre
                if (encoder_zero_in)
                begin
                    cal_run_r   <= 1'b0;
                    cal_found_r <= 1'b1;
                end
                else
                    cal_cnt_r <= cal_cnt_r + {{(PW-1){1'b0}}, 1'b1};
            end
            if (cal_exit_in && cal_found_r && !cal_run_r)
            begin
                nv_offset_out <= cal_cnt_r;
                nv_write_out  <= 1'b1;
                cal_found_r   <= 1'b0;
            end
            cal_busy_out <= cal_run_r;
        end
    end

    // outputs and logger stream; events take precedence over samples
    always @(posedge clk_in)
    begin
        if (rst_in)
        begin
            ready_led_out   <= 1'b0;
            ready_relay_out <= 1'b0;
            relay1_out      <= 1'b0;
            relay2_out      <= 1'b0;
            main_alarm_out  <= 1'b0;
            pre_alarm_out   <= 1'b0;
            ovs_alarm_out   <= 1'b0;
            log_valid_out   <= 1'b0;
            log_tag_out     <= {`ARS_EVT_W{1'b0}};
            log_data_out    <= {DW{1'b0}};
        end
        else
        begin
            ready_led_out   <= ready_r;
            ready_relay_out <= ready_r;
            main_alarm_out  <= main_r;
            pre_alarm_out   <= pre_r;
            ovs_alarm_out   <= ovs_r;
            relay1_out      <= main_r | (r1_pre_en_in & pre_r)
                               | (r1_ovs_en_in & ovs_r);
            relay2_out      <= (r2_main_en_in & main_r)
                               | (r2_pre_en_in & pre_r)
                               | (r2_ovs_en_in & ovs_r);
            log_valid_out   <= 1'b1;
            if (ready_lost_evt_r)
            begin
                log_tag_out  <= {`ARS_EVT_READY_LOST, 4'h0};
                log_data_out <= {{(DW-`ARS_LOSS_CODE_W){1'b0}},
                                 err_code_out};
            end
            else if (main_set_evt_r)
            begin
                log_tag_out  <= {`ARS_EVT_MAIN, 4'h0};
                log_data_out <= peak;
            end
            else if (ovs_set_evt_r)
            begin
                log_tag_out  <= {`ARS_EVT_OVSPD, 4'h0};
                log_data_out <= speed_rpm_in[DW-1:0];
            end
            else if (pre_set_evt_r)
            begin
                log_tag_out  <= {`ARS_EVT_PRE, 4'h0};
                log_data_out <= peak;
            end
            else if (clr_evt_r)
            begin
                log_tag_out  <= {`ARS_EVT_CLEARED, 4'h0};
                log_data_out <= {DW{1'b0}};
            end
            else if (nv_write_out)
            begin
                log_tag_out  <= {`ARS_EVT_OFFSET, 4'h0};
                log_data_out <= nv_offset_out[DW-1:0];
            end
            else if (sample_in)
            begin
                log_tag_out  <= 8'h00; // plain measurement
                log_data_out <= peak;
            end
            else
                log_valid_out <= 1'b0;
        end
    end
endmodule

// ---- testbench/ars_sup_properties.sv ----
// port-level assertions for the alarm relay supervisor
`timescale 1ns/100ps
module ars_sup_properties
#(
    parameter HOLD_CYC     = 20,
    parameter SELFTEST_CYC = 10
)
(
    // clock and reset
    input wire       clk_in,
    input wire       rst_in,
    // pins and configuration
    input wire       reset_button_in,
    input wire       comm_error_in,
    input wire       cal_exit_in,
    input wire       remote_clear_in,
    input wire       r2_main_en_in,
    input wire       r2_pre_en_in,
    input wire       r2_ovs_en_in,
    // outputs
    input wire       ready_led_out,
    input wire       ready_relay_out,
    input wire       relay1_out,
    input wire       relay2_out,
    input wire       main_alarm_out,
    input wire       pre_alarm_out,
    input wire       ovs_alarm_out,
    input wire [3:0] err_code_out,
    input wire       nv_write_out,
    input wire       log_valid_out,
    input wire [7:0] log_tag_out
);
    localparam int ST_MAX = SELFTEST_CYC + 4;
    reg [31:0] run_r;
    reg [31:0] last_r;
    reg [2:0]  comm_r;
    // raw pin run lengths; the last finished run covers a late clear
    always @(posedge clk_in)
    begin
        if (rst_in)
        begin
            run_r  <= 32'h0;
            last_r <= 32'h0;
            comm_r <= 3'h0;
        end
        else
        begin
            run_r  <= reset_button_in ? run_r + 32'h1 : 32'h0;
            last_r <= (!reset_button_in && run_r != 0) ? run_r : last_r;
            comm_r <= {comm_r[2] | comm_r[1], comm_r[0], comm_error_in};
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    AST_MAIN_HOLD:
        assert property ($fell(main_alarm_out) |->
            (run_r >= HOLD_CYC || last_r >= HOLD_CYC))
        else $error("main alarm cleared without full hold");
    AST_OVS_HOLD:
        assert property ($fell(ovs_alarm_out) |->
            (run_r >= HOLD_CYC || last_r >= HOLD_CYC))
        else $error("overspeed alarm cleared without full hold");
    AST_MAIN_READY:
        assert property ($rose(main_alarm_out) |-> $past(ready_led_out))
        else $error("main alarm raised while not ready");
    AST_RELAY1_MAIN:
        assert property (main_alarm_out |-> relay1_out)
        else $error("relay one not following main alarm");
    AST_RELAY2_SEL:
        assert property (relay2_out ==
            (($past(r2_main_en_in) && main_alarm_out) ||
             ($past(r2_pre_en_in) && pre_alarm_out) ||
             ($past(r2_ovs_en_in) && ovs_alarm_out)))
        else $error("relay two does not match its selection");
    AST_READY_PAIR:
        assert property (ready_led_out == ready_relay_out)
        else $error("ready lamp and ready relay disagree");
    AST_COMM_STAYS:
        assert property (comm_r[2] && !ready_led_out |=> !ready_led_out)
        else $error("ready returned after communication fault");
    AST_COMM_DROP:
        assert property ($rose(comm_r[2]) |-> ##[0:ST_MAX] !ready_led_out)
        else $error("ready not dropped after communication fault");
    AST_REMOTE:
        assert property (remote_clear_in [*6] ##0 main_alarm_out
            |=> main_alarm_out)
        else $error("remote command cleared main alarm");
    AST_NV_PULSE:
        assert property (nv_write_out |-> $past(cal_exit_in) ##1 !nv_write_out)
        else $error("offset store pulse not tied to menu exit");
    AST_LOSS_EVT:
        assert property ($fell(ready_led_out) |-> ##[0:3] (log_valid_out &&
            log_tag_out == 8'h10 && err_code_out != 4'h0))
        else $error("ready loss without code and logged event");
endmodule
bind ars_supervisor ars_sup_properties #(
    .HOLD_CYC(HOLD_CYC),
    .SELFTEST_CYC(SELFTEST_CYC)
) i_ars_sup_properties (
    .clk_in(clk_in), .rst_in(rst_in), .reset_button_in(reset_button_in),
    .comm_error_in(comm_error_in), .cal_exit_in(cal_exit_in),
    .remote_clear_in(remote_clear_in), .r2_main_en_in(r2_main_en_in),
    .r2_pre_en_in(r2_pre_en_in), .r2_ovs_en_in(r2_ovs_en_in),
    .ready_led_out(ready_led_out), .ready_relay_out(ready_relay_out),
    .relay1_out(relay1_out), .relay2_out(relay2_out),
    .main_alarm_out(main_alarm_out), .pre_alarm_out(pre_alarm_out),
    .ovs_alarm_out(ovs_alarm_out), .err_code_out(err_code_out),
    .nv_write_out(nv_write_out), .log_valid_out(log_valid_out),
    .log_tag_out(log_tag_out)
);

// ---- testbench/ars_plant_model.sv ----
// plant side: operator turning the shaft, logger noting record kinds
`timescale 1ns/100ps
module ars_plant_model
(
    // clock
    input  wire       clk_in,
    // logger stream
    input  wire       log_valid_in,
    input  wire [7:0] log_tag_in,
    // shaft sensor lines
    output reg        encoder_zero_out,
    output reg        shaft_forward_out,
    output reg        shaft_step_out
);
    reg [15:0] seen_r = 16'h0000;
    initial
    begin
        encoder_zero_out  = 1'b0;
        shaft_forward_out = 1'b0;
        shaft_step_out    = 1'b0;
    end
    always @(posedge clk_in)
    begin
        if (log_valid_in)
            seen_r[log_tag_in[7:4]] <= 1'b1;
    end
    // starts at dead centre, turns forward slowly, zero on step n
    task turn(input integer n);
        integer k;
        begin
            shaft_forward_out <= 1'b1;
            for (k = 0; k <= n; k = k + 1)
            begin
                repeat (3) @(posedge clk_in);
                shaft_step_out   <= 1'b1;
                encoder_zero_out <= (k == n);
                @(posedge clk_in);
                shaft_step_out   <= 1'b0;
                encoder_zero_out <= 1'b0;
            end
            shaft_forward_out <= 1'b0;
        end
    endtask
endmodule

// ---- testbench/tb_ars_supervisor.sv ----
// self-checking bench for the alarm relay supervisor
`timescale 1ns/100ps
`include "ars_consts.vh"
module tb_ars_supervisor;
    localparam HOLD = 20;
    reg         clk_in = 1'b0;
    reg         rst_in = 1'b1;
    reg         btn = 1'b0, comm = 1'b0, sens = 1'b1, supp = 1'b1;
    reg         samp = 1'b0, cstart = 1'b0, cexit = 1'b0, rclr = 1'b0;
    reg  [11:0] thermo = 12'h000, rise = 12'h000;
    reg  [15:0] spd = 16'h0000;
    reg  [2:0]  lvl = 3'h1;
    reg  [4:0]  cfg = 5'h00;
    reg  [11:0] plvl = 12'h250, rlim = 12'h010;
    reg  [15:0] mspd = 16'h0064, ospd = 16'h0bb8, phold = 16'h0002;
    wire        ezero, fwd, step, led, rrel, rel1, rel2, busy, nvw, lval;
    wire        mainal, preal, ovsal;
    wire [3:0]  ecode;
    wire [15:0] nvoff;
    wire [7:0]  ltag;
    wire [11:0] ldat;
    integer     num_errors = 0;
    integer     n_compared = 0;
    always #2 clk_in = ~clk_in;
    ars_supervisor #(.HOLD_CYC(HOLD), .SELFTEST_CYC(10), .QUAL_CYC(2),
        .PRE_DIV(2)) i_ars_supervisor (
        .clk_in(clk_in), .rst_in(rst_in), .reset_button_in(btn),
        .comm_error_in(comm), .sensor_ok_in(sens), .supply_ok_in(supp),
        .sample_in(samp), .thermo_a_in(thermo), .thermo_b_in(thermo),
        .rise_in(rise), .speed_rpm_in(spd), .encoder_zero_in(ezero),
        .shaft_forward_in(fwd), .shaft_step_in(step), .sens_level_in(lvl),
        .pre_level_in(plvl), .rise_limit_in(rlim),
        .min_speed_in(mspd), .overspeed_rpm_in(ospd),
        .pre_holdoff_in(phold), .r1_pre_en_in(cfg[4]),
        .r1_ovs_en_in(cfg[3]), .r2_main_en_in(cfg[2]), .r2_pre_en_in(cfg[1]),
        .r2_ovs_en_in(cfg[0]), .cal_start_in(cstart), .cal_exit_in(cexit),
        .remote_clear_in(rclr), .ready_led_out(led), .ready_relay_out(rrel),
        .relay1_out(rel1), .relay2_out(rel2), .main_alarm_out(mainal),
        .pre_alarm_out(preal), .ovs_alarm_out(ovsal), .err_code_out(ecode),
        .cal_busy_out(busy), .nv_offset_out(nvoff), .nv_write_out(nvw),
        .log_valid_out(lval), .log_tag_out(ltag), .log_data_out(ldat));
    ars_plant_model i_ars_plant_model (.clk_in(clk_in), .log_valid_in(lval),
        .log_tag_in(ltag), .encoder_zero_out(ezero), .shaft_forward_out(fwd),
        .shaft_step_out(step));
    task check(input logic [15:0] seen, input logic [15:0] exp);
        begin
            n_compared = n_compared + 1;
            if (seen !== exp)
            begin
                num_errors = num_errors + 1;
                $display("MISMATCH at %0t: saw %h wanted %h", $time, seen, exp);
            end
        end
    endtask
    // callers drive inputs by non-blocking assignment at the edge
    task tick(input integer n);
        begin
            repeat (n) @(posedge clk_in);
        end
    endtask
    task wait_until(input integer s, input logic v);
        integer k;
        begin
            k = 0;
            while ((s == 0 ? led : s == 1 ? mainal : nvw) !== v && k < 60)
            begin
                tick(1);
                k = k + 1;
            end
        end
    endtask
    task press(input integer n);
        begin
            btn <= 1'b1;
            tick(n);
            btn <= 1'b0;
            tick(1);
        end
    endtask
    task feed(input [11:0] t, input [11:0] r, input [15:0] s);
        integer k;
        begin
            thermo <= t;
            rise   <= r;
            spd    <= s;
            for (k = 0; k < 4; k = k + 1)
            begin
                tick(1);
                samp <= 1'b1;
                tick(1);
                samp <= 1'b0;
            end
            tick(4);
        end
    endtask
    task do_reset;
        begin
            rst_in <= 1'b1;
            tick(4);
            rst_in <= 1'b0;
        end
    endtask
    task t_ready;
        integer i;
        begin
            wait_until(0, 1'b1);
            check(led, 1'b1);
            for (i = 0; i < 2; i = i + 1)
            begin
                sens <= (i != 0);
                supp <= (i == 0);
                wait_until(0, 1'b0);
                check(rrel, 1'b0);
                check(ecode, i ? `ARS_ERR_OTHER : `ARS_ERR_SENSOR);
                sens <= 1'b1;
                supp <= 1'b1;
                wait_until(0, 1'b1);
                check(rrel, 1'b1);
            end
            $display("test ready done");
        end
    endtask
    task t_main;
        begin
            lvl <= 3'h5;
            feed(12'h300, 12'h020, 16'h01f4);
            check(mainal, 1'b0);
            lvl <= 3'h1;
            feed(12'h300, 12'h008, 16'h01f4);
            feed(12'h300, 12'h020, 16'h0050);
            check(mainal, 1'b0);
            feed(12'h300, 12'h020, 16'h01f4);
            wait_until(1, 1'b1);
            check(rel1, 1'b1);
            feed(12'h100, 12'h000, 16'h01f4);
            tick(40);
            check(mainal, 1'b1);
            rclr <= 1'b1;
            tick(40);
            check(mainal, 1'b1);
            rclr <= 1'b0;
            tick(3);
            press(HOLD - 5);
            press(HOLD - 5);
            tick(4);
            check(mainal, 1'b1);
            press(HOLD + 8);
            tick(3);
            check(mainal, 1'b0);
            $display("test main done");
        end
    endtask
    task t_relays;
        integer i;
        begin
            // long hold-off keeps the pre-alarm up across the relay sweep
            ospd  <= 16'h07d0;
            phold <= 16'h0040;
            feed(12'h260, 12'h000, 16'h07d0);
            check(ovsal, 1'b0);
            feed(12'h260, 12'h000, 16'h07d1);
            check(ovsal, 1'b1);
            check(preal, 1'b1);
            for (i = 0; i < 6; i = i + 1)
            begin
                cfg <= (i == 5) ? 5'h00 : 5'h01 << i;
                tick(3);
                check(rel1, cfg[4] | cfg[3]);
                check(rel2, cfg[1] | cfg[0]);
            end
            phold <= 16'h0002;
            feed(12'h100, 12'h000, 16'h01f4);
            tick(30);
            check(preal, 1'b0);
            check(ovsal, 1'b1);
            press(HOLD + 8);
            tick(3);
            check(ovsal, 1'b0);
            $display("test relays done");
        end
    endtask
    task t_cal;
        begin
            cstart <= 1'b1;
            tick(1);
            cstart <= 1'b0;
            tick(2);
            check(busy, 1'b1);
            i_ars_plant_model.turn(5);
            tick(2);
            cexit <= 1'b1;
            tick(1);
            cexit <= 1'b0;
            wait_until(2, 1'b1);
            check(nvoff, 16'h0005);
            tick(1);
            check(ldat, 16'h0005);
            check(ltag, {`ARS_EVT_OFFSET, 4'h0});
            tick(2);
            check(i_ars_plant_model.seen_r[6], 1'b1);
            check(i_ars_plant_model.seen_r[2], 1'b1);
            check(i_ars_plant_model.seen_r[1], 1'b1);
            $display("test calibration done");
        end
    endtask
    task t_comm;
        begin
            comm <= 1'b1;
            tick(4);
            comm <= 1'b0;
            wait_until(0, 1'b0);
            check(ecode, `ARS_ERR_COMM);
            tick(60);
            check(led, 1'b0);
            do_reset;
            wait_until(0, 1'b1);
            check(led, 1'b1);
            $display("test comm done");
        end
    endtask
    task report_and_stop;
        begin
            $display("compared %0d mismatches %0d", n_compared, num_errors);
            if (num_errors == 0 && n_compared > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    initial
    begin
        do_reset;
        t_ready;
        t_main;
        t_relays;
        t_cal;
        t_comm;
        report_and_stop;
    end
    // the whole run needs about 500 cycles
    initial
    begin
        tick(20000);
        num_errors = num_errors + 1;
        $display("MISMATCH at %0t: watchdog expired", $time);
        report_and_stop;
    end
endmodule
